/* File: rtl/cpm_pkg.sv */
/*
  Constants for the power-mode and cycle-status controller.
  Assumes a single 50 MHz clock domain and an active-low async reset.
*/
`default_nettype none
package cpm_pkg;
  localparam int CPM_CLK_MHZ = 50;
  localparam logic [15:0] CPM_NMI_VECTOR = 16'h0066;
  // Restart latencies, tenths of a clock period
  localparam int CPM_SLEEP_WAKE_TENTHS = 15;
  localparam int CPM_IDLE_WAKE_TENTHS = 95;
  localparam int CPM_SLEEP_WAKE_CYC = CPM_SLEEP_WAKE_TENTHS / 10;
  localparam int CPM_IDLE_WAKE_CYC = CPM_IDLE_WAKE_TENTHS / 10;
  localparam int CPM_IDLE_BUSREQ_EXTRA = 8;
  localparam int CPM_CNT_W = 4;
  localparam logic [CPM_CNT_W-1:0] CPM_SLEEP_WAKE_CNT = CPM_CNT_W'(CPM_SLEEP_WAKE_CYC);
  localparam logic [CPM_CNT_W-1:0] CPM_IDLE_WAKE_CNT = CPM_CNT_W'(CPM_IDLE_WAKE_CYC);
  localparam logic [CPM_CNT_W-1:0] CPM_BUSREQ_CNT = CPM_CNT_W'(CPM_IDLE_BUSREQ_EXTRA);
  localparam logic [CPM_CNT_W-1:0] CPM_CNT_ZERO = 4'h0;
  localparam logic [CPM_CNT_W-1:0] CPM_CNT_ONE = 4'h1;
  // Control register fields
  localparam int CPM_IOCR_HALT_BIT = 5;
  localparam int CPM_CCR_SIX = 6;
  localparam int CPM_CCR_GRANT = 5;
  localparam int CPM_CCR_THREE = 3;
  localparam logic [7:0] CPM_REG_RESET = 8'h00;
  // Avalon register offsets (word addresses)
  localparam logic [1:0] CPM_OFF_IOCR = 2'h0;
  localparam logic [1:0] CPM_OFF_CCR = 2'h1;
  localparam logic [1:0] CPM_OFF_STATUS = 2'h2;
  localparam logic [1:0] CPM_OFF_IEN = 2'h3;
  // Clock output divider selection
  localparam logic [1:0] CPM_CLK_HALF = 2'h0;
  localparam logic [1:0] CPM_CLK_EQUAL = 2'h1;
  localparam logic [1:0] CPM_CLK_DOUBLE = 2'h2;
  // Cycle kinds presented by the core
  typedef enum logic [2:0] {
    CPM_CYC_FETCH1 = 3'b000,
    CPM_CYC_FETCHN = 3'b001,
    CPM_CYC_OTHER = 3'b010,
    CPM_CYC_DMA = 3'b011,
    CPM_CYC_REFRESH = 3'b100
  } cpm_cycle_t;
  typedef enum logic [2:0] {
    CPM_RUN = 3'b000,
    CPM_HALTED = 3'b001,
    CPM_SLEEP = 3'b010,
    CPM_IDLE = 3'b011,
    CPM_WAKE = 3'b100,
    CPM_IDLE_GRANT = 3'b101
  } cpm_state_t;
endpackage
`default_nettype wire

/* File: rtl/cpm_power_ctrl.sv */
/*
  Power-mode sequencer and bus-cycle status encoder for an 8-bit CPU.
  Assumes the CPU core reports cycle kinds, sleep/halt events and
  instruction boundaries on mclk; external pins are synchronised here.
*/
`default_nettype none
module cpm_power_ctrl
  import cpm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // From CPU core
  input wire logic core_sleep_exec,
  input wire logic core_halt,
  input wire logic core_instr_end,
  input wire logic core_cycle_start,
  input wire logic [2:0] core_cycle_kind,
  input wire logic core_in_second_state,
  input wire logic [7:0] core_refresh_addr,
  input wire logic core_interrupt_enable_flag_one,
  input wire logic periph_irq,
  // Pins
  input wire logic nmi_n,
  input wire logic [2:0] ext_irq_n,
  input wire logic wait_n,
  input wire logic bus_req_n,
  // Outputs
  output logic system_clock_out,
  output logic cycle_status_out,
  output logic halt_n,
  output logic opcode_fetch_cycle_out,
  output logic refresh_strobe_n,
  output logic memory_request_n,
  output logic [7:0] refresh_addr_out,
  output logic bus_ack_n,
  output logic cpu_stall,
  output logic periph_enable,
  output logic take_interrupt,
  output logic [15:0] vector_addr
);
  // Pin synchronisers: first stage read only by second stage
  logic [5:0] sync1_reg, sync2_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
    end else begin
      sync1_reg <= {bus_req_n, wait_n, nmi_n, ext_irq_n};
      sync2_reg <= sync1_reg;
    end
  end
  logic [2:0] irq_lvl;
  logic nmi_lvl, wait_lvl, breq_lvl;
  assign irq_lvl = ~sync2_reg[2:0];
  assign nmi_lvl = ~sync2_reg[3];
  assign wait_lvl = ~sync2_reg[4];
  assign breq_lvl = ~sync2_reg[5];

  function automatic logic bitsel(input logic [7:0] r, input int pos);
    bitsel = r[pos];
  endfunction

  // Control registers
  logic [7:0] iocr_reg, iocr_next, ccr_reg, ccr_next;
  logic [2:0] ien_reg, ien_next;
  logic [1:0] clksel_reg, clksel_next;
  logic wr_hit;
  assign wr_hit = avs_write;
  always_comb begin
    iocr_next = iocr_reg;
    ccr_next = ccr_reg;
    ien_next = ien_reg;
    clksel_next = clksel_reg;
    if (wr_hit) begin
      case (avs_address)
        CPM_OFF_IOCR: iocr_next = avs_writedata[7:0];
        CPM_OFF_CCR: begin
          ccr_next = avs_writedata[7:0];
          clksel_next = avs_writedata[9:8];
        end
        CPM_OFF_IEN: ien_next = avs_writedata[2:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      iocr_reg <= CPM_REG_RESET;
      ccr_reg <= CPM_REG_RESET;
      ien_reg <= 3'h0;
      clksel_reg <= CPM_CLK_EQUAL;
    end else begin
      iocr_reg <= iocr_next;
      ccr_reg <= ccr_next;
      ien_reg <= ien_next;
      clksel_reg <= clksel_next;
    end
  end

  logic periph_halt_bit, ccr_six, ccr_three, bus_grant_in_idle_bit;
  assign periph_halt_bit = bitsel(iocr_reg, CPM_IOCR_HALT_BIT);
  assign ccr_six = bitsel(ccr_reg, CPM_CCR_SIX);
  assign ccr_three = bitsel(ccr_reg, CPM_CCR_THREE);
  assign bus_grant_in_idle_bit = bitsel(ccr_reg, CPM_CCR_GRANT);

  // Power state machine
  cpm_state_t state_reg, state_next;
  logic [CPM_CNT_W-1:0] cnt_reg, cnt_next;
  logic grant_latch_reg, grant_latch_next;
  logic service_reg, service_next;
  logic nmi_pend_reg, nmi_pend_next;
  logic nmi_prev_reg;
  logic ext_wake, any_wake, nmi_edge;
  assign nmi_edge = nmi_lvl & ~nmi_prev_reg;
  assign ext_wake = |(irq_lvl & ien_reg);
  // Stopped peripherals cannot wake the core in system stop
  assign any_wake = nmi_lvl | ext_wake | (periph_irq & ~periph_halt_bit);
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    grant_latch_next = grant_latch_reg;
    service_next = 1'b0;
    // Set wins over the consume in the same cycle
    nmi_pend_next = nmi_pend_reg;
    if (service_reg) nmi_pend_next = 1'b0;
    if (nmi_edge) nmi_pend_next = 1'b1;
    case (state_reg)
      CPM_RUN: begin
        if (core_sleep_exec) begin
          // Grant permission is frozen at idle entry
          if (periph_halt_bit && !ccr_six && ccr_three) begin
            state_next = CPM_IDLE;
            grant_latch_next = bus_grant_in_idle_bit;
          end else begin
            state_next = CPM_SLEEP;
          end
        end else if (core_halt) begin
          state_next = CPM_HALTED;
        // Pending flag clears one edge after service; never take it twice
        end else if (nmi_pend_reg && !service_reg && core_instr_end) begin
          service_next = 1'b1;
        end
      end
      CPM_HALTED: begin
        if (!core_halt || nmi_pend_reg) state_next = CPM_RUN;
      end
      CPM_SLEEP: begin
        if (any_wake) begin
          state_next = CPM_WAKE;
          cnt_next = CPM_SLEEP_WAKE_CNT;
        end
      end
      CPM_IDLE: begin
        if (nmi_lvl || ext_wake) begin
          state_next = CPM_WAKE;
          cnt_next = CPM_IDLE_WAKE_CNT;
        end else if (breq_lvl && grant_latch_reg) begin
          state_next = CPM_IDLE_GRANT;
          cnt_next = CPM_BUSREQ_CNT;
        end
      end
      CPM_IDLE_GRANT: begin
        if (cnt_reg != CPM_CNT_ZERO) cnt_next = cnt_reg - CPM_CNT_ONE;
        if (!breq_lvl) state_next = CPM_IDLE;
      end
      CPM_WAKE: begin
        if (cnt_reg > CPM_CNT_ONE) begin
          cnt_next = cnt_reg - CPM_CNT_ONE;
        end else begin
          state_next = CPM_RUN;
          // Interrupt served only with NMI or enable flag set
          service_next = nmi_pend_reg | core_interrupt_enable_flag_one;
        end
      end
      default: state_next = CPM_RUN;
    endcase
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CPM_RUN;
      cnt_reg <= CPM_CNT_ZERO;
      grant_latch_reg <= 1'b0;
      service_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
      nmi_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      grant_latch_reg <= grant_latch_next;
      service_reg <= service_next;
      nmi_pend_reg <= nmi_pend_next;
      nmi_prev_reg <= nmi_lvl;
    end
  end

  logic idle_gated, stopped;
  assign idle_gated = (state_reg == CPM_IDLE);
  assign stopped = (state_reg == CPM_SLEEP) || (state_reg == CPM_IDLE) ||
                   (state_reg == CPM_IDLE_GRANT) || (state_reg == CPM_WAKE);

  // Wait-state tracking: stretch while low is seen in second state
  logic wait_hold_reg, wait_hold_next;
  always_comb begin
    wait_hold_next = 1'b0;
    if ((core_in_second_state || wait_hold_reg) && wait_lvl) wait_hold_next = 1'b1;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) wait_hold_reg <= 1'b0;
    else wait_hold_reg <= wait_hold_next;
  end

  // Clock output divider; idle holds it low, except during an idle bus grant
  logic [2:0] div_reg, div_next;
  logic clk_out_next;
  always_comb begin
    div_next = div_reg + 3'h1;
    // Rates keep a 1:2:4 ratio; double is the fastest mclk allows
    case (clksel_reg)
      CPM_CLK_HALF: clk_out_next = div_reg[2];
      CPM_CLK_DOUBLE: clk_out_next = ~system_clock_out;
      default: clk_out_next = div_reg[1];
    endcase
    if (idle_gated) clk_out_next = 1'b0;
  end

  // Status encoding and refresh
  logic st_next, halt_next, fetch_next, refresh_strobe_n_next, memory_request_n_next, back_next;
  logic [7:0] raddr_next;
  always_comb begin
    st_next = 1'b1;
    halt_next = 1'b1;
    fetch_next = 1'b1;
    refresh_strobe_n_next = 1'b1;
    memory_request_n_next = 1'b1;
    raddr_next = refresh_addr_out;
    back_next = ~(state_reg == CPM_IDLE_GRANT && cnt_reg == CPM_CNT_ZERO);
    if (state_reg == CPM_HALTED) begin
      st_next = 1'b0;
      halt_next = 1'b0;
      fetch_next = 1'b0;
    end else if (stopped) begin
      halt_next = 1'b0;
    end else if (core_cycle_start) begin
      case (core_cycle_kind)
        CPM_CYC_FETCH1: begin
          st_next = 1'b0;
          fetch_next = 1'b0;
        end
        CPM_CYC_FETCHN: fetch_next = 1'b0;
        CPM_CYC_DMA: st_next = 1'b0;
        CPM_CYC_REFRESH: begin
          refresh_strobe_n_next = 1'b0;
          memory_request_n_next = 1'b0;
          raddr_next = core_refresh_addr;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 3'h0;
      system_clock_out <= 1'b0;
      cycle_status_out <= 1'b1;
      halt_n <= 1'b1;
      opcode_fetch_cycle_out <= 1'b1;
      refresh_strobe_n <= 1'b1;
      memory_request_n <= 1'b1;
      refresh_addr_out <= 8'h00;
      bus_ack_n <= 1'b1;
    end else begin
      div_reg <= div_next;
      system_clock_out <= clk_out_next;
      cycle_status_out <= st_next;
      halt_n <= halt_next;
      opcode_fetch_cycle_out <= fetch_next;
      refresh_strobe_n <= refresh_strobe_n_next;
      memory_request_n <= memory_request_n_next;
      refresh_addr_out <= raddr_next;
      bus_ack_n <= back_next;
    end
  end

  assign cpu_stall = stopped | (state_reg == CPM_HALTED) | wait_hold_reg;
  assign periph_enable = ~periph_halt_bit & ~stopped;
  assign take_interrupt = service_reg;
  assign vector_addr = CPM_NMI_VECTOR;

  // Register reads answer in the same cycle
  assign avs_waitrequest = 1'b0;
  always_comb begin
    avs_readdata = 32'h0;
    if (avs_read) begin
      case (avs_address)
        CPM_OFF_IOCR: avs_readdata = {24'h0, iocr_reg};
        CPM_OFF_CCR: avs_readdata = {22'h0, clksel_reg, ccr_reg};
        CPM_OFF_STATUS: avs_readdata = {28'h0, grant_latch_reg, state_reg};
        CPM_OFF_IEN: avs_readdata = {29'h0, ien_reg};
        default: avs_readdata = 32'h0;
      endcase
    end
  end
endmodule // cpm_power_ctrl
`default_nettype wire

/* File: dv/cpm_ext_model.sv */
/*
  External partner: memory that stretches cycles, and a bus requester.
  Assumes it sits on the controller's pins and runs from mclk.
*/
`default_nettype none
module cpm_ext_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic memory_request_n,
  input wire logic [3:0] wait_len,
  input wire logic ext_req,
  output logic wait_n,
  output logic bus_req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_reg;
  // Slow memory: holds wait low for wait_len cycles after each request
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      left_reg <= 4'h0;
      bus_req_n <= 1'b1;
    end else begin
      if (!memory_request_n && left_reg == 4'h0) begin
        left_reg <= wait_len;
      end else if (left_reg != 4'h0) begin
        left_reg <= left_reg - 4'h1;
      end
      bus_req_n <= !ext_req;
    end
  end
  // Zero length gives a prompt memory, no stretch at all
  assign wait_n = (left_reg == 4'h0);
endmodule // cpm_ext_model
`default_nettype wire

/* File: dv/cpm_monitor.sv */
/*
  Checker on the controller's pins.
  Assumes the single mclk domain and the active-low reset.
*/
`default_nettype none
module cpm_monitor (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic core_cycle_start,
  input wire logic [2:0] core_cycle_kind,
  input wire logic core_in_second_state,
  input wire logic wait_n,
  input wire logic [15:0] vector_addr,
  input wire logic refresh_strobe_n,
  input wire logic memory_request_n,
  input wire logic cycle_status_out,
  input wire logic halt_n,
  input wire logic opcode_fetch_cycle_out,
  input wire logic cpu_stall,
  input wire logic periph_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Steps of a peripheral-halt write and of a held wait
  sequence s_io_wr(v);
    avs_write && avs_address == 2'h0 && avs_writedata[5] == v;
  endsequence
  sequence s_wait_held;
    (core_in_second_state && !wait_n) [*5];
  endsequence
  property p_vec; vector_addr == 16'h0066; endproperty
  property p_refresh_strobe_n; !refresh_strobe_n |-> !memory_request_n; endproperty
  property p_stop_code; !halt_n |-> cycle_status_out == opcode_fetch_cycle_out; endproperty
  property p_fetch1;
    core_cycle_start && core_cycle_kind == 3'h0 |-> ##[1:3] !cycle_status_out
      && !opcode_fetch_cycle_out;
  endproperty
  property p_dma;
    core_cycle_start && core_cycle_kind == 3'h3 |-> ##[1:3] !cycle_status_out
      && opcode_fetch_cycle_out;
  endproperty
  property p_io_stop; s_io_wr(1'b1) |-> ##[1:3] !periph_enable; endproperty
  property p_io_run; s_io_wr(1'b0) |-> ##[1:3] periph_enable; endproperty
  property p_reset; $rose(reset_n) |-> periph_enable; endproperty
  property p_wait; s_wait_held |-> cpu_stall; endproperty
  a_vec: assert property (p_vec) else $error("vector not 0066");
  a_refresh_strobe_n: assert property (p_refresh_strobe_n) else $error("refresh without request");
  a_stop_code: assert property (p_stop_code) else $error("bad stop code");
  a_fetch1: assert property (p_fetch1) else $error("bad fetch code");
  a_dma: assert property (p_dma) else $error("bad dma code");
  a_io_stop: assert property (p_io_stop) else $error("peripherals run");
  a_io_run: assert property (p_io_run) else $error("peripherals stopped");
  a_reset: assert property (p_reset) else $error("peripherals off at reset");
  a_wait: assert property (p_wait) else $error("no stall in wait");
endmodule // cpm_monitor
bind cpm_power_ctrl cpm_monitor u_mon (.mclk, .reset_n, .avs_address, .avs_write,
  .avs_writedata, .core_cycle_start, .core_cycle_kind, .core_in_second_state, .wait_n,
  .vector_addr, .refresh_strobe_n, .memory_request_n, .cycle_status_out, .halt_n,
  .opcode_fetch_cycle_out, .cpu_stall, .periph_enable);
`default_nettype wire

/* File: dv/tb.sv */
/*
  Bench: register tasks over the slave port and power-mode scenarios.
  Assumes the external model on the wait and bus request pins.
*/
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
`define WAITV(c, lim, n) begin k = 0; while (!(c) && k < lim) begin @(posedge mclk); \
  k++; end `CHK(n, 1'b1, (c)) end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cpm_pkg::*;
  logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, core_sleep_exec, core_halt;
  logic core_instr_end, core_cycle_start, core_in_second_state, interrupt_enable_flag_one, periph_irq, nmi_n;
  logic wait_n, bus_req_n, system_clock_out, cycle_status_out, halt_n, fetch_out;
  logic refresh_strobe_n, memory_request_n, bus_ack_n, cpu_stall, periph_enable, ext_req;
  logic take_interrupt;
  logic [1:0] avs_address;
  logic [2:0] core_cycle_kind, ext_irq_n;
  logic [3:0] wait_len;
  logic [7:0] refresh_addr_out;
  logic [15:0] vector_addr;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] codes [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  int n_errors, comparisons, k, c;
  cpm_power_ctrl dut (.mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .core_sleep_exec, .core_halt, .core_instr_end,
    .core_cycle_start, .core_cycle_kind, .core_in_second_state,
    .core_refresh_addr(8'hA5), .core_interrupt_enable_flag_one(interrupt_enable_flag_one), .periph_irq, .nmi_n,
    .ext_irq_n, .wait_n, .bus_req_n, .system_clock_out, .cycle_status_out, .halt_n,
    .opcode_fetch_cycle_out(fetch_out), .refresh_strobe_n, .memory_request_n,
    .refresh_addr_out, .bus_ack_n, .cpu_stall, .periph_enable, .take_interrupt, .vector_addr);
  cpm_ext_model u_ext (.mclk, .reset_n, .memory_request_n, .wait_len, .ext_req, .wait_n,
    .bus_req_n);
  // Free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task wr(input logic [1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task rdr(input logic [1:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  // Count clock-out changes over 40 cycles
  task tog(output int n);
    logic p;
    n = 0;
    p = system_clock_out;
    repeat (40) begin
      @(posedge mclk);
      if (system_clock_out !== p) n++;
      p = system_clock_out;
    end
  endtask
  task sleep_op();
    core_sleep_exec <= 1'b1;
    @(posedge mclk);
    core_sleep_exec <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    {avs_read, avs_write, core_sleep_exec, core_halt, core_cycle_start, periph_irq} = '0;
    {core_in_second_state, ext_req, reset_n, avs_address, core_cycle_kind} = '0;
    {core_instr_end, interrupt_enable_flag_one, nmi_n, ext_irq_n} = '1;
    avs_writedata = '0;
    wait_len = 4'h0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rdr(CPM_OFF_IOCR);
    `CHK("iocr", 8'h00, rd[7:0])
    wr(CPM_OFF_IEN, 32'h7);
    wr(CPM_OFF_IOCR, 32'h20);
    rdr(CPM_OFF_IOCR);
    `CHK("iocr", 8'h20, rd[7:0])
    `CHK("periph", 1'b0, periph_enable)
    wr(CPM_OFF_IOCR, 32'h0);
    `CHK("periph", 1'b1, periph_enable)
    for (int i = 0; i < 3; i++) begin
      wr(CPM_OFF_CCR, 32'(i) << 8);
      tog(c);
      `CHK("clk", 1'b1, (c >= (10 << i) - 2 && c <= (10 << i) + 2))
    end
    $display("registers and clock done");
    // Kinds 0..3 give their code, kind 4 a refresh with 8-bit address
    for (int i = 0; i < 5; i++) begin
      core_cycle_kind <= 3'(i);
      core_cycle_start <= 1'b1;
      @(posedge mclk);
      core_cycle_start <= 1'b0;
      if (i == 4) `WAITV(refresh_strobe_n === 1'b0, 4, "refresh_strobe_n")
      else @(posedge mclk); // Code stands for one cycle only
      if (i == 4) `CHK("raddr", 8'hA5, refresh_addr_out)
      else `CHK("code", codes[i], {cycle_status_out, fetch_out})
    end
    core_halt <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("halt", 3'b000, {cycle_status_out, halt_n, fetch_out})
    core_halt <= 1'b0;
    @(posedge mclk);
    wait_len <= 4'h8;
    core_in_second_state <= 1'b1;
    // Refresh drives the memory request that the slow memory stretches
    core_cycle_kind <= CPM_CYC_REFRESH;
    core_cycle_start <= 1'b1;
    @(posedge mclk);
    core_cycle_start <= 1'b0;
    `WAITV(cpu_stall === 1'b1, 12, "stall")
    `WAITV(cpu_stall === 1'b0, 16, "resume")
    core_in_second_state <= 1'b0;
    $display("cycles done");
    wr(CPM_OFF_IOCR, 32'h20);
    sleep_op();
    `CHK("stop", 3'b101, {cycle_status_out, halt_n, fetch_out})
    periph_irq <= 1'b1;
    tog(c);
    `CHK("stop clk", 1'b1, c > 0)
    `CHK("no wake", 1'b0, halt_n)
    periph_irq <= 1'b0;
    ext_irq_n <= 3'b110;
    `WAITV(halt_n === 1'b1, 6, "wake")
    ext_irq_n <= 3'b111;
    $display("system stop done");
    wr(CPM_OFF_CCR, 32'h128);
    sleep_op();
    rdr(CPM_OFF_STATUS);
    `CHK("idle", CPM_IDLE, rd[2:0])
    tog(c);
    `CHK("idle clk", 0, c)
    ext_req <= 1'b1;
    `WAITV(bus_ack_n === 1'b0, 20, "grant")
    ext_req <= 1'b0;
    `WAITV(bus_ack_n === 1'b1, 8, "ungrant")
    tog(c);
    `CHK("regated", 0, c)
    nmi_n <= 1'b0;
    `WAITV(take_interrupt === 1'b1, 24, "nmi")
    @(posedge mclk);
    `CHK("one nmi", 1'b0, take_interrupt)
    nmi_n <= 1'b1;
    rdr(CPM_OFF_STATUS);
    `CHK("run", CPM_RUN, rd[2:0])
    $display("idle done");
    // Enabled irq wakes idle with the enable flag clear: no service
    interrupt_enable_flag_one <= 1'b0;
    sleep_op();
    ext_irq_n <= 3'b110;
    c = 0;
    repeat (20) begin
      @(posedge mclk);
      if (take_interrupt === 1'b1) c++;
    end
    `CHK("no irq", 0, c)
    ext_irq_n <= 3'b111;
    rdr(CPM_OFF_STATUS);
    `CHK("resumed", CPM_RUN, rd[2:0])
    $display("idle without enable done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
